// ### core/dma_hs_device.sv
// Purpose: device end, grants DMA channels and runs stretchable cycles
// Assumes: request and wait inputs synchronous to i_clk
// Notes: lowest-numbered pending channel wins; one transfer per grant
`timescale 1ns/1ps
`include "dma_hs_regs.svh"
module dma_hs_device
	import dma_hs_pkg::*;
#(
	parameter logic [3:0] BASE_CYCLES = `DMA_BASE_CYCLES,
	parameter logic [3:0] CTRL_CYCLES = `DMA_CTRL_CYCLES
) (
	// Clock and control
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Controller access request and last-transfer flag for tc
	input wire logic i_ctrl_req,
	input wire logic i_last,
	// Link
	dma_hs_if.device link,
	// Status
	output logic o_busy,
	output logic [1:0] o_channel,
	output logic o_ctrl_done
);
	dev_state_e state, next_state;
	logic [3:0] count, next_count;
	logic [3:0] grant_n, next_grant_n;
	logic tc, next_tc;
	logic [1:0] chan, next_chan;
	logic done, next_done;

	function automatic logic [1:0] pick(input logic [3:0] req);
		pick = req[0] ? 2'h0 : req[1] ? 2'h1 : req[2] ? 2'h2 : 2'h3;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_count = count;
		next_grant_n = grant_n;
		next_tc = 1'b0;
		next_chan = chan;
		next_done = 1'b0;
		case (state)
			DEV_IDLE: begin
				// Controller access first: its cycles have fixed length
				if (i_ctrl_req) begin
					next_state = DEV_CTRL;
					next_count = CTRL_CYCLES;
				end else if (|link.dma_channel_request) begin
					next_chan = pick(link.dma_channel_request);
					next_grant_n = `DMA_GRANT_IDLE;
					next_grant_n[pick(link.dma_channel_request)] = 1'b0;
					next_state = DEV_DMA;
					next_count = BASE_CYCLES;
				end
			end
			DEV_DMA: begin
				// Low wait sample adds a state instead of counting down
				if (!link.wait_line) begin
					next_count = count;
				end else if (count == 4'h1) begin
					next_state = DEV_DONE;
					next_tc = i_last;
				end else begin
					next_count = count - 4'h1;
				end
			end
			DEV_CTRL: begin
				// Wait line deliberately ignored here
				if (count == 4'h1) begin
					next_state = DEV_IDLE;
					next_done = 1'b1;
				end else begin
					next_count = count - 4'h1;
				end
			end
			DEV_DONE: begin
				next_grant_n = `DMA_GRANT_IDLE;
				next_state = DEV_IDLE;
			end
			default: begin
				next_state = DEV_IDLE;
				next_grant_n = `DMA_GRANT_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= DEV_IDLE;
			count <= 4'h0;
			grant_n <= `DMA_GRANT_IDLE;
			tc <= 1'b0;
			chan <= 2'h0;
			done <= 1'b0;
		end else if (i_ce) begin
			state <= next_state;
			count <= next_count;
			grant_n <= next_grant_n;
			tc <= next_tc;
			chan <= next_chan;
			done <= next_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign link.dma_channel_grant_n = grant_n;
	assign link.tc = tc;
	assign link.cmd_active = (state == DEV_DMA) || (state == DEV_CTRL);
	assign o_busy = (state != DEV_IDLE);
	assign o_channel = chan;
	assign o_ctrl_done = done;
endmodule

// ### core/dma_hs_regs.svh
// Purpose: constants for the DMA request/grant and cycle extension link
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: all timing is in clock cycles
`ifndef DMA_HS_REGS_SVH
`define DMA_HS_REGS_SVH
`define DMA_CHANNELS 4
`define DMA_BASE_CYCLES 4'h4
`define DMA_CTRL_CYCLES 4'h4
`define DMA_GRANT_IDLE 4'hF
`endif

// ### core/dma_hs_pkg.sv
// Purpose: state types for both ends of the DMA request/grant link
// Assumes: one-hot state codes
// Notes: timing constants live in dma_hs_regs.svh
package dma_hs_pkg;
	typedef enum logic [3:0] {
		DEV_IDLE = 4'h1,
		DEV_DMA = 4'h2,
		DEV_CTRL = 4'h4,
		DEV_DONE = 4'h8
	} dev_state_e;
	typedef enum logic [2:0] {
		PER_IDLE = 3'h1,
		PER_REQ = 3'h2,
		PER_XFER = 3'h4
	} per_state_e;
endpackage

// ### core/dma_hs_if.sv
// Purpose: carrier joining the device end and the peripheral end
// Assumes: wait line is a wired pull-low that floats high
// Notes: wait_pull_n stands for any other slave sharing the wait line
`timescale 1ns/1ps
interface dma_hs_if;
	logic [3:0] dma_channel_request;
	logic [3:0] dma_channel_grant_n;
	logic tc;
	logic cmd_active;
	logic wait_o;
	logic wait_oe;
	// Second slave on the same wired line, high when released
	logic wait_pull_n;
	// Open-drain wait: floats high unless a slave pulls low
	logic wait_line;
	assign wait_line = (wait_oe ? wait_o : 1'b1) & wait_pull_n;
	modport device (
		input dma_channel_request,
		input wait_line,
		output dma_channel_grant_n,
		output tc,
		output cmd_active
	);
	modport peripheral (
		input dma_channel_grant_n,
		input tc,
		input cmd_active,
		output dma_channel_request,
		output wait_o,
		output wait_oe
	);
endinterface

// ### core/dma_hs_peripheral.sv
// Purpose: peripheral end, requests a channel and stretches DMA cycles
// Assumes: signals synchronous to i_clk
// Notes: wait is driven low only while a command is seen
`timescale 1ns/1ps
`include "dma_hs_regs.svh"
module dma_hs_peripheral
	import dma_hs_pkg::*;
#(
	parameter logic [1:0] CHANNEL = 2'h0
) (
	// Clock and control
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// User side
	input wire logic i_request,
	input wire logic [3:0] i_wait_cycles,
	// Link
	dma_hs_if.peripheral link,
	// Status
	output logic o_granted,
	output logic o_tc_seen
);
	per_state_e state, next_state;
	logic [3:0] wait_left, next_wait_left;
	logic tc_seen, next_tc_seen;
	logic granted;

	assign granted = !link.dma_channel_grant_n[CHANNEL];

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_wait_left = wait_left;
		next_tc_seen = tc_seen | link.tc;
		case (state)
			PER_IDLE: begin
				if (i_request) begin
					next_state = PER_REQ;
				end
			end
			PER_REQ: begin
				// Request stays up until the grant appears
				if (granted) begin
					next_state = PER_XFER;
					next_wait_left = i_wait_cycles;
				end
			end
			PER_XFER: begin
				if (link.cmd_active && wait_left != 4'h0) begin
					next_wait_left = wait_left - 4'h1;
				end
				if (!granted) begin
					next_state = PER_IDLE;
				end
			end
			default: begin
				next_state = PER_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state <= PER_IDLE;
			wait_left <= 4'h0;
			tc_seen <= 1'b0;
		end else if (i_ce) begin
			state <= next_state;
			wait_left <= next_wait_left;
			tc_seen <= next_tc_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		link.dma_channel_request = 4'h0;
		link.dma_channel_request[CHANNEL] = (state == PER_REQ);
	end
	// Released as soon as the count runs out, line floats high
	assign link.wait_o = 1'b0;
	assign link.wait_oe = (state == PER_XFER) && link.cmd_active && wait_left != 4'h0;
	assign o_granted = granted;
	assign o_tc_seen = tc_seen;
endmodule

// ### verif/dma_hs_chk.sv
// Purpose: link checker
// Assumes: one clock, sync reset
// Notes: watches interface nets only
`timescale 1ns/1ps
module dma_hs_chk (
	// Clock, reset and link nets
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [3:0] dma_channel_request,
	input wire logic [3:0] dma_channel_grant_n,
	input wire logic tc,
	input wire logic cmd_active,
	input wire logic wait_oe,
	input wire logic wait_line
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	AST_ONE_GRANT: assert property ($onehot0(~dma_channel_grant_n))
		else $error("more than one grant");
	AST_GRANT_CAUSE: assert property ($fell(&dma_channel_grant_n) |->
		($past(dma_channel_request) & ~dma_channel_grant_n) != 4'h0)
		else $error("grant without request");
	AST_REQ_HOLD: assert property (($past(dma_channel_request) &
		~dma_channel_request & $past(dma_channel_grant_n)) == 4'h0)
		else $error("request dropped before grant");
	AST_WAIT_CMD: assert property (wait_oe |-> cmd_active)
		else $error("wait outside command");
	AST_WAIT_DMA: assert property (wait_oe |-> !(&dma_channel_grant_n))
		else $error("wait outside dma cycle");
	AST_WAIT_DONE: assert property (tc |-> !wait_oe)
		else $error("wait held at done");
	AST_TC_DONE: assert property (tc |-> !cmd_active && !(&dma_channel_grant_n))
		else $error("tc outside done cycle");
	AST_STRETCH: assert property (cmd_active && !(&dma_channel_grant_n) && !wait_line
		|=> cmd_active)
		else $error("cycle ended during wait");
	// Controller cycle keeps its length whatever the wait line does
	AST_CTRL_LEN: assert property ($rose(cmd_active) && &dma_channel_grant_n |->
		cmd_active [*4] ##1 !cmd_active)
		else $error("controller cycle length changed");
	AST_BASE_LEN: assert property ($fell(&dma_channel_grant_n) |-> cmd_active [*4])
		else $error("dma cycle too short");
	AST_RELEASE: assert property (tc |=> &dma_channel_grant_n)
		else $error("grant held after tc");
	COV_WAIT: cover property (wait_oe);
	COV_TC: cover property (tc);
	COV_GRANT: cover property ($fell(&dma_channel_grant_n));
	COV_CTRL_WAIT: cover property (cmd_active && &dma_channel_grant_n && !wait_line);
endmodule

// ### verif/tb_top.sv
// Purpose: bench for both link ends
// Assumes: peripheral on channel 2
// Notes: inputs change at falling edge
`timescale 1ns/1ps
module tb_top;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, i_ce = 1'b1, i_ctrl_req = 1'b0, i_last = 1'b0;
	logic i_request = 1'b0, sticky = 1'b0;
	logic [3:0] i_wait_cycles = 4'h0;
	logic busy, ctrl_done, granted, tc_seen;
	logic [1:0] chan;
	int n_errors = 0, checks = 0, n, pulses;
	dma_hs_if link ();
	always #25 i_clk = ~i_clk;
	dma_hs_device dma_hs_device_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(i_ce),
		.i_ctrl_req(i_ctrl_req), .i_last(i_last), .link(link.device), .o_busy(busy),
		.o_channel(chan), .o_ctrl_done(ctrl_done));
	dma_hs_peripheral #(.CHANNEL(2'h2)) dma_hs_peripheral_i (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_request(i_request),
		.i_wait_cycles(i_wait_cycles), .link(link.peripheral), .o_granted(granted),
		.o_tc_seen(tc_seen));
	dma_hs_chk dma_hs_chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.dma_channel_request(link.dma_channel_request),
		.dma_channel_grant_n(link.dma_channel_grant_n), .tc(link.tc),
		.cmd_active(link.cmd_active), .wait_oe(link.wait_oe), .wait_line(link.wait_line));
	////////////////////////////////////////////////////////////////////////
	task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s exp %0h got %0h", what, exp, got);
		end
	endtask
	task close_out;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Grant length is base count, one per wait sample, one done cycle
	task dma_xfer(input logic [3:0] k, input logic last, input logic [3:0] stall);
		@(negedge i_clk);
		i_wait_cycles = k;
		i_last = last;
		i_request = 1'b1;
		n = 0;
		while (&link.dma_channel_grant_n && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		i_request = 1'b0;
		cmp("grant", 8'h0B, {4'h0, link.dma_channel_grant_n});
		cmp("channel", 8'h02, {6'h00, chan});
		cmp("granted", 8'h01, {7'h00, granted});
		cmp("busy", 8'h01, {7'h00, busy});
		// Frozen cycles must not count towards the grant length
		if (stall != 4'h0) begin
			i_ce = 1'b0;
			repeat (stall) @(negedge i_clk);
			i_ce = 1'b1;
		end
		n = 0;
		pulses = 0;
		while (!(&link.dma_channel_grant_n) && n < 40) begin
			@(negedge i_clk);
			n++;
			if (link.tc === 1'b1) pulses++;
		end
		// Seen flag is sticky until reset
		sticky = sticky | last;
		cmp("grant_len", 8'h05 + k, 8'(n));
		cmp("tc_pulses", {7'h00, last}, 8'(pulses));
		cmp("tc_seen", {7'h00, sticky}, {7'h00, tc_seen});
		cmp("busy_end", 8'h00, {7'h00, busy});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		link.wait_pull_n = 1'b1;
		repeat (6) @(negedge i_clk);
		i_sys_rst = 1'b0;
		dma_xfer(4'h0, 1'b0, 4'h0);
		dma_xfer(4'h3, 1'b1, 4'h3);
		@(negedge i_clk);
		i_ctrl_req = 1'b1;
		i_wait_cycles = 4'h2;
		i_request = 1'b1;
		@(negedge i_clk);
		i_ctrl_req = 1'b0;
		// Another slave holds wait low through the controller cycle
		link.wait_pull_n = 1'b0;
		cmp("ctrl_first", 8'h0F, {4'h0, link.dma_channel_grant_n});
		n = 0;
		while (ctrl_done !== 1'b1 && n < 20) begin
			@(negedge i_clk);
			n++;
		end
		link.wait_pull_n = 1'b1;
		cmp("ctrl_done", 8'h01, {7'h00, ctrl_done});
		cmp("ctrl_len", 8'h04, 8'(n));
		dma_xfer(4'h2, 1'b0, 4'h0);
		close_out();
	end
	initial begin
		#20000;
		n_errors++;
		close_out();
	end
endmodule
